/* File: core/dsp_host_byte_port.sv */
// Byte-wide host port exchanging 16-bit words with the DSP side
`timescale 1ns/1ps
module dsp_host_byte_port
    import host_port_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              host_sel_n,
    input  wire logic              host_write_n,
    input  wire logic              host_addr_bit1,
    input  wire logic              host_addr_bit0,
    input  wire logic [BYTE_W-1:0] host_data_in,
    output logic      [BYTE_W-1:0] host_data_out,
    output logic                   host_data_oe,
    output logic                   bus_ack_n_out,
    output logic                   bus_ack_oe,
    output logic                   in_request_n,
    output logic                   out_request_n,
    output logic      [WORD_W-1:0] dsp_in_data,
    output logic                   dsp_in_valid,
    input  wire logic              dsp_in_ready,
    input  wire logic [WORD_W-1:0] dsp_out_data,
    input  wire logic              dsp_out_valid,
    output logic                   dsp_out_ready,
    input  wire logic              dsp_order_we,
    input  wire logic              dsp_order_value
);

    // True when the access reaches the high byte of a word
    function automatic logic high_half(input logic a0, input logic order);
        high_half = ~(a0 ^ order);
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    host_bus_type     pin_raw;
    host_bus_type     pin_meta_reg;
    host_bus_type     pin_reg;

    assign pin_raw = '{sel: ~host_sel_n, write: ~host_write_n,
                       addr: {host_addr_bit1, host_addr_bit0}, data: host_data_in};

    always_ff @(posedge clk) begin
        if (srst) begin
            pin_meta_reg <= '0;
            pin_reg      <= '0;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_reg      <= pin_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------
    access_state_type state_reg;
    logic [WORD_W-1:0] in_word_reg;
    logic [WORD_W-1:0] out_word_reg;
    logic              in_empty_reg;
    logic              out_full_reg;
    logic              in_irq_en_reg;
    logic              out_irq_en_reg;
    logic              byte_order_reg;
    logic              in_half_reg;
    logic              out_half_reg;
    logic              skid_valid_reg;
    logic [WORD_W-1:0] skid_data_reg;
    logic              buf_ready;
    logic              word_access;
    logic              hold_off;
    logic              do_access;
    logic              wr_first;
    logic              wr_second;
    logic              rd_first;
    logic              rd_second;
    logic              wr_status;
    logic              in_push;
    logic              out_load;
    logic [BYTE_W-1:0] status_byte;
    logic [BYTE_W-1:0] read_byte;

    assign word_access = (pin_reg.addr == ADDR_FIRST) || (pin_reg.addr == ADDR_SECOND);
    // Word writes wait while the previous word is still held
    assign hold_off    = pin_reg.write && word_access && !in_empty_reg;
    assign do_access   = (state_reg == ST_EXEC) && pin_reg.sel && !hold_off;
    assign wr_first    = do_access && pin_reg.write && (pin_reg.addr == ADDR_FIRST);
    assign wr_second   = do_access && pin_reg.write && (pin_reg.addr == ADDR_SECOND);
    assign rd_first    = do_access && !pin_reg.write && (pin_reg.addr == ADDR_FIRST);
    assign rd_second   = do_access && !pin_reg.write && (pin_reg.addr == ADDR_SECOND);
    assign wr_status   = do_access && pin_reg.write && (pin_reg.addr == ADDR_STATUS);
    assign buf_ready   = !skid_valid_reg;
    assign in_push     = !in_empty_reg && buf_ready;
    assign out_load    = dsp_out_valid && !out_full_reg;

    always_comb begin
        status_byte = '0;
        status_byte[BIT_IN_EMPTY]   = in_empty_reg;
        status_byte[BIT_OUT_FULL]   = out_full_reg;
        status_byte[BIT_IN_IRQ_EN]  = in_irq_en_reg;
        status_byte[BIT_OUT_IRQ_EN] = out_irq_en_reg;
        status_byte[BIT_BYTE_ORDER] = byte_order_reg;
    end

    always_comb begin
        read_byte = '0;
        if (pin_reg.addr == ADDR_STATUS) begin
            read_byte = status_byte;
        end else if (word_access) begin
            if (high_half(pin_reg.addr[0], byte_order_reg)) begin
                read_byte = out_word_reg[WORD_W-1:BYTE_W];
            end else begin
                read_byte = out_word_reg[BYTE_W-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (pin_reg.sel) begin
                        state_reg <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (!pin_reg.sel) begin
                        state_reg <= ST_IDLE;
                    end else if (!hold_off) begin
                        state_reg <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (!pin_reg.sel) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Host pin drivers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            host_data_out <= '0;
            host_data_oe  <= 1'b0;
            bus_ack_n_out <= 1'b1;
            bus_ack_oe    <= 1'b0;
        end else begin
            if (do_access) begin
                host_data_out <= read_byte;
                host_data_oe  <= !pin_reg.write;
                bus_ack_n_out <= 1'b0;
                bus_ack_oe    <= 1'b1;
            end else if (!pin_reg.sel) begin
                host_data_oe  <= 1'b0;
                bus_ack_n_out <= 1'b1;
                bus_ack_oe    <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Input word register and flags
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            in_word_reg <= '0;
        end else if (wr_first || wr_second) begin
            if (high_half(pin_reg.addr[0], byte_order_reg)) begin
                in_word_reg[WORD_W-1:BYTE_W] <= pin_reg.data;
            end else begin
                in_word_reg[BYTE_W-1:0] <= pin_reg.data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            in_empty_reg <= RST_IN_EMPTY;
        end else if (in_push) begin
            in_empty_reg <= 1'b1;
        end else if (wr_second) begin
            in_empty_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            in_half_reg  <= 1'b0;
            out_half_reg <= 1'b0;
        end else begin
            if (wr_second) begin
                in_half_reg <= 1'b0;
            end else if (wr_first) begin
                in_half_reg <= 1'b1;
            end
            if (rd_second) begin
                out_half_reg <= 1'b0;
            end else if (rd_first) begin
                out_half_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Two-entry buffer towards the DSP
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            dsp_in_valid   <= 1'b0;
            dsp_in_data    <= '0;
            skid_valid_reg <= 1'b0;
            skid_data_reg  <= '0;
        end else begin
            if (!dsp_in_valid || dsp_in_ready) begin
                if (skid_valid_reg) begin
                    dsp_in_data    <= skid_data_reg;
                    dsp_in_valid   <= 1'b1;
                    skid_valid_reg <= 1'b0;
                end else begin
                    dsp_in_data  <= in_word_reg;
                    dsp_in_valid <= in_push;
                end
            end else if (in_push) begin
                skid_data_reg  <= in_word_reg;
                skid_valid_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Output word register and flag
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            out_word_reg <= '0;
            out_full_reg <= RST_OUT_FULL;
        end else begin
            if (out_load && dsp_out_ready) begin
                out_word_reg <= dsp_out_data;
                out_full_reg <= 1'b1;
            end else if (rd_second) begin
                out_full_reg <= 1'b0;
            end
        end
    end

    // One-cycle ready pulse, at most one load per two cycles
    always_ff @(posedge clk) begin
        if (srst) begin
            dsp_out_ready <= 1'b0;
        end else begin
            dsp_out_ready <= !out_full_reg && !dsp_out_ready;
        end
    end

    // ------------------------------------------------------------------
    // Control bits and request lines
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            in_irq_en_reg  <= RST_IN_IRQ_EN;
            out_irq_en_reg <= RST_OUT_IRQ_EN;
        end else if (wr_status) begin
            in_irq_en_reg  <= pin_reg.data[BIT_IN_IRQ_EN];
            out_irq_en_reg <= pin_reg.data[BIT_OUT_IRQ_EN];
        end
    end

    // Byte order set from the DSP side only; read-only to the host
    always_ff @(posedge clk) begin
        if (srst) begin
            byte_order_reg <= RST_BYTE_ORDER;
        end else if (dsp_order_we) begin
            byte_order_reg <= dsp_order_value;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            in_request_n  <= 1'b1;
        end else begin
            in_request_n  <= !(in_irq_en_reg && in_empty_reg && !in_half_reg);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            out_request_n <= 1'b1;
        end else begin
            out_request_n <= !(out_irq_en_reg && out_full_reg && !out_half_reg);
        end
    end

endmodule

/* File: pkg/host_port_pkg.sv */
// Constants and carrier types for the DSP host byte port
// ----------------------------------------------------------------------
// Overview of operation
// - Host writes a 16-bit input word register it cannot read back.
// - Host reads a 16-bit output word register it cannot write.
// - Each word moves as two byte accesses; address bit 0 and byte order pick halves.
// - Address 00 reaches high byte (order 0) or low byte (order 1); no status change.
// - Address 01 reaches the other byte; write clears input-empty, read clears output-full.
// - Address 11 read returns status unchanged; address 10 reserved, no status change.
// - Status register has five meaningful bits; bits 7 to 5 read zero.
// - Byte-order bit 4 host-readable; 1 means low byte first; resets to 1.
// - Status bit 3 enables the output request line; resets to 0.
// - Status bit 2 enables the input request line; resets to 0.
// - Status bit 1 shows output word waiting for host; resets to 0.
// - Status bit 0 shows input word register empty; resets to 1.
// - Active-low requests follow flags and enables, drop after first byte; input request returns after second, output request once a new word loads.
// - Accesses acknowledged on bus acknowledge; write to full input register held off.
// ----------------------------------------------------------------------
package host_port_pkg;

    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;

    localparam logic [1:0] ADDR_FIRST    = 2'h0;
    localparam logic [1:0] ADDR_SECOND   = 2'h1;
    localparam logic [1:0] ADDR_RESERVED = 2'h2;
    localparam logic [1:0] ADDR_STATUS   = 2'h3;

    localparam int BIT_IN_EMPTY   = 0;
    localparam int BIT_OUT_FULL   = 1;
    localparam int BIT_IN_IRQ_EN  = 2;
    localparam int BIT_OUT_IRQ_EN = 3;
    localparam int BIT_BYTE_ORDER = 4;

    localparam logic RST_IN_EMPTY   = 1'b1;
    localparam logic RST_OUT_FULL   = 1'b0;
    localparam logic RST_IN_IRQ_EN  = 1'b0;
    localparam logic RST_OUT_IRQ_EN = 1'b0;
    localparam logic RST_BYTE_ORDER = 1'b1;

    // Host strobes and data as seen on the pins
    typedef struct packed {
        logic              sel;
        logic              write;
        logic [1:0]        addr;
        logic [BYTE_W-1:0] data;
    } host_bus_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_ACK  = 2'b11
    } access_state_type;

endpackage

/* File: tb/dsp_host_byte_port_test.sv */
// Self-checking bench for the host byte port
`timescale 1ns/1ps
module dsp_host_byte_port_test
    import host_port_pkg::*;
;
    logic clk = 1'b0, srst, sel_n, wr_n, a1, a0, doe, ackn, ackoe, irq_in_n, irq_out_n;
    logic ivalid, iready, ovalid, oready, owe, oval, stall;
    logic [7:0]  din, dout, q;
    logic [15:0] idata, odata;
    int errors = 0, cmp_count = 0, waited;
    initial forever #4 clk = ~clk;
    dsp_host_byte_port DUT (.clk(clk), .srst(srst), .host_sel_n(sel_n), .host_write_n(wr_n),
        .host_addr_bit1(a1), .host_addr_bit0(a0), .host_data_in(din), .host_data_out(dout),
        .host_data_oe(doe), .bus_ack_n_out(ackn), .bus_ack_oe(ackoe), .in_request_n(irq_in_n),
        .out_request_n(irq_out_n), .dsp_in_data(idata), .dsp_in_valid(ivalid),
        .dsp_in_ready(iready), .dsp_out_data(odata), .dsp_out_valid(ovalid),
        .dsp_out_ready(oready), .dsp_order_we(owe), .dsp_order_value(oval));
    dsp_side_model M (.clk(clk), .stall(stall), .dsp_in_data(idata), .dsp_in_valid(ivalid),
        .dsp_in_ready(iready), .dsp_out_data(odata), .dsp_out_valid(ovalid),
        .dsp_out_ready(oready));
    task automatic report_and_stop();
        $display("compares %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One host access, select held until acknowledged
    task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d);
        int n;
        @(negedge clk);
        sel_n = 1'b0;
        wr_n = !w;
        {a1, a0} = a;
        din = w ? d : ~din;
        waited = 0;
        do begin @(posedge clk); waited++; end while (ackoe !== 1'b1 && waited < 400);
        q = dout;
        if (waited >= 400) begin errors++; report_and_stop(); end
        chk("read drive", {15'h0, !w}, {15'h0, doe});
        chk("ack level", 16'h0000, {15'h0, ackn});
        @(negedge clk);
        sel_n = 1'b1;
        din = ~din;
        n = 0;
        while (ackoe !== 1'b0 && n < 20) begin @(negedge clk); n++; end
        if (n >= 20) begin errors++; report_and_stop(); end
        repeat (2) @(negedge clk);
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rdc(input logic [1:0] a, input logic [7:0] e, input string nm);
        acc(1'b0, a, 8'h00);
        chk(nm, {8'h00, e}, {8'h00, q});
    endtask
    // Status polling until the given flag is set
    task automatic poll(input int b);
        int k;
        k = 0;
        do begin acc(1'b0, 2'h3, 8'h00); k++; end while (q[b] !== 1'b1 && k < 50);
        if (q[b] !== 1'b1) begin errors++; report_and_stop(); end
    endtask
    task automatic set_order(input logic v);
        @(negedge clk);
        owe = 1'b1;
        oval = v;
        @(negedge clk);
        owe = 1'b0;
    endtask
    initial begin
        srst = 1'b1; sel_n = 1'b1; wr_n = 1'b1; a1 = 1'b0; a0 = 1'b0; din = 8'h00;
        owe = 1'b0; oval = 1'b0; stall = 1'b0;
        repeat (20) @(posedge clk);
        @(negedge clk) srst = 1'b0;
        rdc(2'h3, 8'h11, "status reset");
        chk("requests idle", 16'h0003, {14'h0, irq_in_n, irq_out_n});
        wr(2'h2, 8'hFF);
        acc(1'b0, 2'h2, 8'h00);
        rdc(2'h3, 8'h11, "status reserved");
        stall = 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr(2'h0, 8'h10 + 8'(i));
            rdc(2'h3, 8'h11, "status first byte");
            wr(2'h1, 8'hA0 + 8'(i));
        end
        rdc(2'h3, 8'h10, "status input full");
        fork
            wr(2'h0, 8'h55);
            begin repeat (60) @(negedge clk); stall = 1'b0; end
        join
        chk("held off", 16'h0001, {15'h0, waited >= 50});
        wr(2'h1, 8'h66);
        repeat (20) @(negedge clk);
        chk("word count", 16'h0004, 16'(M.got.size()));
        for (int i = 0; i < 3; i++) chk("dsp word", {8'hA0 + 8'(i), 8'h10 + 8'(i)}, M.got[i]);
        chk("dsp word", 16'h6655, M.got[3]);
        rdc(2'h3, 8'h11, "status drained");
        set_order(1'b0);
        rdc(2'h3, 8'h01, "status order 0");
        wr(2'h0, 8'hAB);
        wr(2'h1, 8'hCD);
        set_order(1'b1);
        wr(2'h3, 8'h0C);
        rdc(2'h3, 8'h1D, "status enables");
        chk("order 0 word", 16'hABCD, M.got[4]);
        chk("requests", 16'h0001, {14'h0, irq_in_n, irq_out_n});
        poll(BIT_IN_EMPTY);
        wr(2'h0, 8'h01);
        chk("in request first", 16'h0001, {15'h0, irq_in_n});
        wr(2'h1, 8'h02);
        repeat (4) @(negedge clk);
        chk("in request second", 16'h0000, {15'h0, irq_in_n});
        M.send(16'h5678, waited);
        if (waited >= 100) begin errors++; report_and_stop(); end
        repeat (4) @(negedge clk);
        rdc(2'h3, 8'h1F, "status out full");
        chk("out request", 16'h0000, {15'h0, irq_out_n});
        poll(BIT_OUT_FULL);
        rdc(2'h0, 8'h78, "out first byte");
        chk("out request first", 16'h0001, {15'h0, irq_out_n});
        rdc(2'h3, 8'h1F, "status after first");
        rdc(2'h1, 8'h56, "out second byte");
        rdc(2'h3, 8'h1D, "status out taken");
        report_and_stop();
    end
endmodule

/* File: tb/dsp_side_model.sv */
// Behavioural DSP side: word sink with stall and word source
`timescale 1ns/1ps
module dsp_side_model (
    input  wire logic        clk,
    input  wire logic        stall,
    input  wire logic [15:0] dsp_in_data,
    input  wire logic        dsp_in_valid,
    output logic             dsp_in_ready,
    output logic      [15:0] dsp_out_data,
    output logic             dsp_out_valid,
    input  wire logic        dsp_out_ready
);
    logic [15:0] got[$];
    initial begin
        dsp_out_valid = 1'b0;
        dsp_out_data = 16'h0000;
    end
    always @(negedge clk) dsp_in_ready <= !stall;
    always @(posedge clk) if (dsp_in_valid && dsp_in_ready) got.push_back(dsp_in_data);
    task automatic send(input logic [15:0] w, output int n);
        @(negedge clk);
        dsp_out_valid = 1'b1;
        dsp_out_data = w;
        n = 0;
        do begin @(posedge clk); n++; end while (dsp_out_ready !== 1'b1 && n < 100);
        @(negedge clk);
        dsp_out_valid = 1'b0;
        dsp_out_data = ~w;
    endtask
endmodule

/* File: tb/host_port_asserts.sv */
// Concurrent checks on the host byte port pins
`timescale 1ns/1ps
module host_port_asserts
    import host_port_pkg::*;
(
    input wire logic              clk,
    input wire logic              srst,
    input wire logic              host_sel_n,
    input wire logic              host_write_n,
    input wire logic              host_data_oe,
    input wire logic              bus_ack_n_out,
    input wire logic              bus_ack_oe,
    input wire logic              in_request_n,
    input wire logic              out_request_n,
    input wire logic [WORD_W-1:0] dsp_in_data,
    input wire logic              dsp_in_valid,
    input wire logic              dsp_in_ready,
    input wire logic              dsp_out_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_rd_start;
        $fell(host_sel_n) && host_write_n;
    endsequence
    property p_rd_ack;
        s_rd_start |-> ##[2:8] (bus_ack_oe && host_data_oe);
    endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("read not answered");
    property p_ack_low;
        bus_ack_oe |-> !bus_ack_n_out;
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("ack level high");
    property p_oe_read;
        host_data_oe |-> host_write_n && bus_ack_oe;
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("data driven on write");
    property p_ack_cause;
        $rose(bus_ack_oe) |-> !$past(host_sel_n, 2);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without select");
    property p_ack_drop;
        host_sel_n [*5] |-> !bus_ack_oe;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack stuck");
    property p_hold;
        dsp_in_valid && !dsp_in_ready |=> dsp_in_valid && $stable(dsp_in_data);
    endproperty
    a_hold: assert property (p_hold) else $error("word lost in stall");
    property p_out_pulse;
        dsp_out_ready |=> !dsp_out_ready;
    endproperty
    a_out_pulse: assert property (p_out_pulse) else $error("ready not a pulse");
    property p_reset;
        disable iff (1'b0) srst |=> in_request_n && out_request_n && !dsp_in_valid
            && !bus_ack_oe && !host_data_oe;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset outputs");
endmodule

bind dsp_host_byte_port host_port_asserts u_chk (.clk(clk), .srst(srst),
    .host_sel_n(host_sel_n), .host_write_n(host_write_n), .host_data_oe(host_data_oe),
    .bus_ack_n_out(bus_ack_n_out), .bus_ack_oe(bus_ack_oe), .in_request_n(in_request_n),
    .out_request_n(out_request_n), .dsp_in_data(dsp_in_data), .dsp_in_valid(dsp_in_valid),
    .dsp_in_ready(dsp_in_ready), .dsp_out_ready(dsp_out_ready));
